/* inc/sgy_params.svh */
`ifndef SGY_PARAMS_SVH
`define SGY_PARAMS_SVH

// external control register addresses
`define SGY_EXT_SLEEP      3'h3
`define SGY_EXT_PIN_CTRL   3'h4
`define SGY_EXT_SOFT_SYNC  3'h5

// per-channel register addresses
`define SGY_CH_START_HO    8'h83
`define SGY_CH_HOP_HO      8'h84
`define SGY_CH_FREQ        8'h85
`define SGY_CH_PIN_SEL     8'h86

// field positions in external registers 4 and 5
`define SGY_BIT_START      4
`define SGY_BIT_HOP        5

// reset values
`define SGY_SLEEP_RESET    4'hF
`define SGY_HOLDOFF_RESET  16'h0000
`define SGY_FREQ_RESET     32'h0000_0000
`define SGY_PIN_SEL_RESET  2'h0
`define SGY_CTRL_RESET     8'h00

// latencies in master clock cycles beyond the hold-off value
`define SGY_LAT_SOFT_START 6
`define SGY_LAT_PIN_START  3
`define SGY_LAT_SOFT_HOP   7
`define SGY_LAT_PIN_HOP    5
`define SGY_SYNC_STAGES    2

// derived pipeline depths
`define SGY_START_FIRE_DLY (`SGY_LAT_PIN_START - `SGY_SYNC_STAGES - 1)
`define SGY_HOP_FIRE_DLY   (`SGY_LAT_PIN_HOP - `SGY_SYNC_STAGES - 1)
`define SGY_SOFT_START_DLY (`SGY_LAT_SOFT_START - 1 - `SGY_START_FIRE_DLY)
`define SGY_SOFT_HOP_DLY   (`SGY_LAT_SOFT_HOP - 1 - `SGY_HOP_FIRE_DLY)

`endif

/* inc/sgy_pkg.sv */
package sgy_pkg;

  typedef enum logic {
    cnt_idle,
    cnt_run
  } sgy_cnt_state_type;

endpackage

/* design/sgy_pin_sync.sv */
`timescale 1ns/100ps
module sgy_pin_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // raw pins
  input  wire logic [W-1:0] pin_i,
  // synchronised level and rising edge
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;

  // two-flop synchroniser, third flop for edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~last;

endmodule

/* design/sgy_holdoff_counter.sv */
`timescale 1ns/100ps
module sgy_holdoff_counter #(
  parameter int CNT_W    = 16,
  parameter int FIRE_DLY = 0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // trigger and hold-off value
  input  wire logic             trig_i,
  input  wire logic [CNT_W-1:0] holdoff_i,
  // status and completion
  output logic                  busy_o,
  output logic                  fire_o
);

  sgy_pkg::sgy_cnt_state_type state;
  sgy_pkg::sgy_cnt_state_type next_state;
  logic [CNT_W-1:0]           cnt;
  logic [CNT_W-1:0]           next_cnt;
  logic                       fire_now;

  assign fire_now = (state == sgy_pkg::cnt_run) && (cnt <= CNT_W'(1));

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      sgy_pkg::cnt_idle: begin
        if (trig_i) begin
          next_state = sgy_pkg::cnt_run;
          next_cnt   = holdoff_i;
        end
      end
      sgy_pkg::cnt_run: begin
        if (trig_i) begin
          next_cnt = holdoff_i;
        end else if (fire_now) begin
          next_state = sgy_pkg::cnt_idle;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = sgy_pkg::cnt_idle;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= sgy_pkg::cnt_idle;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign busy_o = (state == sgy_pkg::cnt_run);

  generate
    if (FIRE_DLY == 0) begin : g_direct
      assign fire_o = fire_now;
    end else begin : g_piped
      logic [FIRE_DLY-1:0] pipe;
      logic [FIRE_DLY-1:0] next_pipe;
      always_comb begin
        next_pipe = FIRE_DLY'({pipe, fire_now});
      end
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pipe <= '0;
        end else begin
          pipe <= next_pipe;
        end
      end
      assign fire_o = pipe[FIRE_DLY-1];
    end
  endgenerate

endmodule

/* design/sgy_chan_sync.sv */
`timescale 1ns/100ps
`include "sgy_params.svh"
// Notes on behaviour
// - hard reset puts all four channels to sleep
// - sleep bits in external register 3; high sleeps, low runs
// - start plus soft sync write starts start hold-off countdown each clock
// - start countdown at 1 clears sleep bits of the selected channels
// - soft start: acknowledge rise to running is hold-off plus 6 clocks
// - each channel watches any one of four sync pins
// - start-on-pin bit plus pin enable: pin rise starts countdown
// - pin start: pin rise to running is hold-off plus 3 clocks
// - zero hop hold-off: frequency write goes to oscillator at once
// - hop plus soft sync write starts frequency hold-off countdown
// - hop countdown at 1 moves pending frequency into oscillator
// - soft hop: acknowledge rise to new frequency is hold-off plus 7
// - hop-on-pin bit plus pin enable: pin rise starts hop countdown
// - pin hop: pin rise to new frequency is hold-off plus 5
// - new frequency is held pending and delayed by hop hold-off
// - shadow register plus hold-off counter enabled by soft or pin sync
module sgy_chan_sync #(
  parameter int CNT_W  = 16,
  parameter int FREQ_W = 32
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // external control register access
  input  wire logic                ext_wr_i,
  input  wire logic                ext_rd_i,
  input  wire logic [2:0]          ext_addr_i,
  input  wire logic [7:0]          ext_wdata_i,
  output logic      [7:0]          ext_rdata_o,
  // per-channel register access
  input  wire logic                chan_wr_i,
  input  wire logic                chan_rd_i,
  input  wire logic [1:0]          chan_sel_i,
  input  wire logic [7:0]          chan_addr_i,
  input  wire logic [FREQ_W-1:0]   chan_wdata_i,
  output logic      [FREQ_W-1:0]   chan_rdata_o,
  output logic                     write_acknowledge_o,
  // external sync pins
  input  wire logic [3:0]          sync_pin_i,
  // channel state
  output logic      [3:0]          sleep_o,
  output logic      [3:0]          start_busy_o,
  output logic      [3:0]          hop_busy_o,
  output logic      [4*FREQ_W-1:0] tuning_oscillator_freq_o
);

  localparam int NCH = 4;
  localparam int SSD = `SGY_SOFT_START_DLY;
  localparam int SHD = `SGY_SOFT_HOP_DLY;

  // host-visible registers
  logic [3:0]        sleep;
  logic [3:0]        next_sleep;
  logic [7:0]        pin_ctrl;
  logic [7:0]        next_pin_ctrl;
  logic [7:0]        soft_ctrl;
  logic [7:0]        next_soft_ctrl;
  logic [CNT_W-1:0]  start_ho [NCH];
  logic [CNT_W-1:0]  next_start_ho [NCH];
  logic [CNT_W-1:0]  hop_ho [NCH];
  logic [CNT_W-1:0]  next_hop_ho [NCH];
  logic [FREQ_W-1:0] pend_freq [NCH];
  logic [FREQ_W-1:0] next_pend_freq [NCH];
  logic [FREQ_W-1:0] act_freq [NCH];
  logic [FREQ_W-1:0] next_act_freq [NCH];
  logic [1:0]        pin_sel [NCH];
  logic [1:0]        next_pin_sel [NCH];

  // soft sync delay lines, one channel mask per stage
  logic [3:0]        ss_pipe [SSD+1];
  logic [3:0]        next_ss_pipe [SSD+1];
  logic [3:0]        sh_pipe [SHD+1];
  logic [3:0]        next_sh_pipe [SHD+1];

  // host answer
  logic              ack;
  logic              next_ack;
  logic [7:0]        ext_rdata;
  logic [7:0]        next_ext_rdata;
  logic [FREQ_W-1:0] chan_rdata;
  logic [FREQ_W-1:0] next_chan_rdata;

  // sync and countdown wiring
  logic [3:0]        pin_rise;
  logic [3:0]        pin_hit;
  logic [3:0]        start_trig;
  logic [3:0]        hop_trig;
  logic [3:0]        start_fire;
  logic [3:0]        hop_fire;
  logic              soft_wr;
  logic              ch_wr_freq;

  sgy_pin_sync #(
    .W (4)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (sync_pin_i),
    .level_o (),
    .rise_o  (pin_rise)
  );

  assign soft_wr    = ext_wr_i && (ext_addr_i == `SGY_EXT_SOFT_SYNC);
  assign ch_wr_freq = chan_wr_i && (chan_addr_i == `SGY_CH_FREQ);

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      // channel picks one pin; enable gates it
      assign pin_hit[c] = pin_rise[pin_sel[c]] & pin_ctrl[pin_sel[c]];

      assign start_trig[c] = ss_pipe[SSD][c] |
                             (pin_ctrl[`SGY_BIT_START] & pin_hit[c]);
      assign hop_trig[c]   = sh_pipe[SHD][c] |
                             (pin_ctrl[`SGY_BIT_HOP] & pin_hit[c]);

      sgy_holdoff_counter #(
        .CNT_W    (CNT_W),
        .FIRE_DLY (`SGY_START_FIRE_DLY)
      ) u_start_cnt (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .trig_i    (start_trig[c]),
        .holdoff_i (start_ho[c]),
        .busy_o    (start_busy_o[c]),
        .fire_o    (start_fire[c])
      );

      sgy_holdoff_counter #(
        .CNT_W    (CNT_W),
        .FIRE_DLY (`SGY_HOP_FIRE_DLY)
      ) u_hop_cnt (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .trig_i    (hop_trig[c]),
        .holdoff_i (hop_ho[c]),
        .busy_o    (hop_busy_o[c]),
        .fire_o    (hop_fire[c])
      );

      assign tuning_oscillator_freq_o[c*FREQ_W +: FREQ_W] = act_freq[c];
    end
  endgenerate

  // register file next values
  always_comb begin
    next_sleep     = sleep;
    next_pin_ctrl  = pin_ctrl;
    next_soft_ctrl = soft_ctrl;
    for (int i = 0; i < NCH; i++) begin
      next_start_ho[i]  = start_ho[i];
      next_hop_ho[i]    = hop_ho[i];
      next_pend_freq[i] = pend_freq[i];
      next_act_freq[i]  = act_freq[i];
      next_pin_sel[i]   = pin_sel[i];
    end
    if (ext_wr_i) begin
      case (ext_addr_i)
        `SGY_EXT_SLEEP: begin
          next_sleep = ext_wdata_i[3:0];
        end
        `SGY_EXT_PIN_CTRL: begin
          next_pin_ctrl = ext_wdata_i;
        end
        `SGY_EXT_SOFT_SYNC: begin
          next_soft_ctrl = ext_wdata_i;
        end
        default: begin
        end
      endcase
    end
    if (chan_wr_i) begin
      case (chan_addr_i)
        `SGY_CH_START_HO: begin
          next_start_ho[chan_sel_i] = chan_wdata_i[CNT_W-1:0];
        end
        `SGY_CH_HOP_HO: begin
          next_hop_ho[chan_sel_i] = chan_wdata_i[CNT_W-1:0];
        end
        `SGY_CH_FREQ: begin
          next_pend_freq[chan_sel_i] = chan_wdata_i;
        end
        `SGY_CH_PIN_SEL: begin
          next_pin_sel[chan_sel_i] = chan_wdata_i[1:0];
        end
        default: begin
        end
      endcase
    end
    for (int i = 0; i < NCH; i++) begin
      // countdown done wakes channel, over a same-cycle host write
      if (start_fire[i]) begin
        next_sleep[i] = 1'b0;
      end
      if (hop_fire[i]) begin
        next_act_freq[i] = pend_freq[i];
      end else if (ch_wr_freq && (chan_sel_i == 2'(i)) &&
                   (hop_ho[i] == CNT_W'(0))) begin
        next_act_freq[i] = chan_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep     <= `SGY_SLEEP_RESET;
      pin_ctrl  <= `SGY_CTRL_RESET;
      soft_ctrl <= `SGY_CTRL_RESET;
      for (int i = 0; i < NCH; i++) begin
        start_ho[i]  <= `SGY_HOLDOFF_RESET;
        hop_ho[i]    <= `SGY_HOLDOFF_RESET;
        pend_freq[i] <= `SGY_FREQ_RESET;
        act_freq[i]  <= `SGY_FREQ_RESET;
        pin_sel[i]   <= `SGY_PIN_SEL_RESET;
      end
    end else begin
      sleep     <= next_sleep;
      pin_ctrl  <= next_pin_ctrl;
      soft_ctrl <= next_soft_ctrl;
      for (int i = 0; i < NCH; i++) begin
        start_ho[i]  <= next_start_ho[i];
        hop_ho[i]    <= next_hop_ho[i];
        pend_freq[i] <= next_pend_freq[i];
        act_freq[i]  <= next_act_freq[i];
        pin_sel[i]   <= next_pin_sel[i];
      end
    end
  end

  // soft sync delay lines align countdown to the acknowledge
  always_comb begin
    next_ss_pipe[0] = 4'h0;
    next_sh_pipe[0] = 4'h0;
    if (soft_wr && ext_wdata_i[`SGY_BIT_START]) begin
      next_ss_pipe[0] = ext_wdata_i[3:0];
    end
    if (soft_wr && ext_wdata_i[`SGY_BIT_HOP]) begin
      next_sh_pipe[0] = ext_wdata_i[3:0];
    end
    for (int i = 1; i <= SSD; i++) begin
      next_ss_pipe[i] = ss_pipe[i-1];
    end
    for (int i = 1; i <= SHD; i++) begin
      next_sh_pipe[i] = sh_pipe[i-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i <= SSD; i++) begin
        ss_pipe[i] <= 4'h0;
      end
      for (int i = 0; i <= SHD; i++) begin
        sh_pipe[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i <= SSD; i++) begin
        ss_pipe[i] <= next_ss_pipe[i];
      end
      for (int i = 0; i <= SHD; i++) begin
        sh_pipe[i] <= next_sh_pipe[i];
      end
    end
  end

  // acknowledge and read data
  always_comb begin
    next_ack        = ext_wr_i | ext_rd_i | chan_wr_i | chan_rd_i;
    next_ext_rdata  = ext_rdata;
    next_chan_rdata = chan_rdata;
    if (ext_rd_i) begin
      case (ext_addr_i)
        `SGY_EXT_SLEEP:     next_ext_rdata = {4'h0, sleep};
        `SGY_EXT_PIN_CTRL:  next_ext_rdata = pin_ctrl;
        `SGY_EXT_SOFT_SYNC: next_ext_rdata = soft_ctrl;
        default:            next_ext_rdata = 8'h00;
      endcase
    end
    if (chan_rd_i) begin
      case (chan_addr_i)
        `SGY_CH_START_HO: next_chan_rdata = FREQ_W'(start_ho[chan_sel_i]);
        `SGY_CH_HOP_HO:   next_chan_rdata = FREQ_W'(hop_ho[chan_sel_i]);
        `SGY_CH_FREQ:     next_chan_rdata = pend_freq[chan_sel_i];
        `SGY_CH_PIN_SEL:  next_chan_rdata = FREQ_W'(pin_sel[chan_sel_i]);
        default:          next_chan_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack        <= 1'b0;
      ext_rdata  <= 8'h00;
      chan_rdata <= '0;
    end else begin
      ack        <= next_ack;
      ext_rdata  <= next_ext_rdata;
      chan_rdata <= next_chan_rdata;
    end
  end

  assign write_acknowledge_o = ack;
  assign ext_rdata_o         = ext_rdata;
  assign chan_rdata_o        = chan_rdata;
  assign sleep_o             = sleep;

endmodule

/* verification/sgy_chan_sync_properties.sv */
`timescale 1ns/100ps
module sgy_chan_sync_properties #(
  parameter int CNT_W  = 16,
  parameter int FREQ_W = 32
) (
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  // host ports
  input wire logic                ext_wr_i,
  input wire logic                ext_rd_i,
  input wire logic [2:0]          ext_addr_i,
  input wire logic [7:0]          ext_wdata_i,
  input wire logic [7:0]          ext_rdata_o,
  input wire logic                chan_wr_i,
  input wire logic                chan_rd_i,
  input wire logic [1:0]          chan_sel_i,
  input wire logic [7:0]          chan_addr_i,
  input wire logic [FREQ_W-1:0]   chan_wdata_i,
  input wire logic [FREQ_W-1:0]   chan_rdata_o,
  input wire logic                write_acknowledge_o,
  // pins and state
  input wire logic [3:0]          sync_pin_i,
  input wire logic [3:0]          sleep_o,
  input wire logic [3:0]          start_busy_o,
  input wire logic [3:0]          hop_busy_o,
  input wire logic [4*FREQ_W-1:0] tuning_oscillator_freq_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic any_acc;
  assign any_acc = ext_wr_i | ext_rd_i | chan_wr_i | chan_rd_i;

  a_reset_asleep: assert property ($rose(rst_n_i) |-> sleep_o == 4'hF)
    else $error("sleep bits not set after reset");
  a_ack_follows: assert property (write_acknowledge_o == $past(any_acc))
    else $error("acknowledge not one cycle after access");
  a_sleep_write: assert property (ext_wr_i && ext_addr_i == 3'h3 && start_busy_o == 4'h0
    |=> sleep_o == $past(ext_wdata_i[3:0])) else $error("sleep write lost");
  a_sleep_rise_cause: assert property ($rose(sleep_o[0])
    |-> $past(ext_wr_i && ext_addr_i == 3'h3 && ext_wdata_i[0])) else $error("sleep rose");
  a_sleep_fall_cause: assert property ($fell(sleep_o[1])
    |-> $past(ext_wr_i && ext_addr_i == 3'h3) || $fell(start_busy_o[1]))
    else $error("sleep fell without cause");
  a_start_wakes: assert property ($fell(start_busy_o[3]) |-> !sleep_o[3])
    else $error("countdown end did not wake channel");
  a_freq_cause: assert property ($changed(tuning_oscillator_freq_o[63:32])
    |-> $past(chan_wr_i && chan_sel_i == 2'h1 && chan_addr_i == 8'h85)
    || $past(hop_busy_o[1]) || $past(hop_busy_o[1], 2) || $past(hop_busy_o[1], 3)
    || $past(hop_busy_o[1], 4)) else $error("frequency changed without cause");
  a_start_stays_idle: assert property ($fell(start_busy_o[2]) |=> !start_busy_o[2] [*2])
    else $error("start countdown restarted");
  a_hop_stays_idle: assert property ($fell(hop_busy_o[2]) |=> !hop_busy_o[2] [*2])
    else $error("hop countdown restarted");
endmodule

bind sgy_chan_sync sgy_chan_sync_properties #(.CNT_W(CNT_W), .FREQ_W(FREQ_W))
  i_sgy_chan_sync_properties (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_wr_i(ext_wr_i),
  .ext_rd_i(ext_rd_i), .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i),
  .ext_rdata_o(ext_rdata_o), .chan_wr_i(chan_wr_i), .chan_rd_i(chan_rd_i),
  .chan_sel_i(chan_sel_i), .chan_addr_i(chan_addr_i), .chan_wdata_i(chan_wdata_i),
  .chan_rdata_o(chan_rdata_o), .write_acknowledge_o(write_acknowledge_o),
  .sync_pin_i(sync_pin_i), .sleep_o(sleep_o), .start_busy_o(start_busy_o),
  .hop_busy_o(hop_busy_o), .tuning_oscillator_freq_o(tuning_oscillator_freq_o));

/* verification/sgy_sync_src.sv */
`timescale 1ns/100ps
module sgy_sync_src (
  // clock
  input  wire logic       clk_i,
  // pulse request
  input  wire logic       go_i,
  input  wire logic [1:0] pin_sel_i,
  // sync pins, low when idle
  output logic      [3:0] pin_o
);
  logic       armed;
  logic [2:0] hold;
  always @(posedge clk_i) begin
    armed <= go_i;
  end
  always @(negedge clk_i) begin
    if (armed) begin
      pin_o <= 4'h1 << pin_sel_i;
      hold <= 3'h4;
    end else if (hold > 3'h1) begin
      hold <= hold - 3'h1;
    end else begin
      pin_o <= 4'h0;
      hold <= 3'h0;
    end
  end
endmodule

/* verification/tb_sgy_chan_sync.sv */
`timescale 1ns/100ps
module tb_sgy_chan_sync;
  logic         clk_i;
  logic         rst_n_i;
  logic         ext_wr_i;
  logic         ext_rd_i;
  logic [2:0]   ext_addr_i;
  logic [7:0]   ext_wdata_i;
  logic [7:0]   ext_rdata_o;
  logic         chan_wr_i;
  logic         chan_rd_i;
  logic [1:0]   chan_sel_i;
  logic [7:0]   chan_addr_i;
  logic [31:0]  chan_wdata_i;
  logic [31:0]  chan_rdata_o;
  logic         write_acknowledge_o;
  logic [3:0]   sync_pin_i;
  logic [3:0]   sleep_o;
  logic [3:0]   start_busy_o;
  logic [3:0]   hop_busy_o;
  logic [127:0] tuning_oscillator_freq_o;
  logic         go;
  logic [1:0]   go_pin;
  logic [31:0]  rd;
  int           num_errors;
  int           num_checks;

  sgy_chan_sync i_sgy_chan_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .ext_wr_i(ext_wr_i),
    .ext_rd_i(ext_rd_i), .ext_addr_i(ext_addr_i), .ext_wdata_i(ext_wdata_i),
    .ext_rdata_o(ext_rdata_o), .chan_wr_i(chan_wr_i), .chan_rd_i(chan_rd_i),
    .chan_sel_i(chan_sel_i), .chan_addr_i(chan_addr_i), .chan_wdata_i(chan_wdata_i),
    .chan_rdata_o(chan_rdata_o), .write_acknowledge_o(write_acknowledge_o),
    .sync_pin_i(sync_pin_i), .sleep_o(sleep_o), .start_busy_o(start_busy_o),
    .hop_busy_o(hop_busy_o), .tuning_oscillator_freq_o(tuning_oscillator_freq_o));
  sgy_sync_src i_sgy_sync_src (.clk_i(clk_i), .go_i(go), .pin_sel_i(go_pin),
    .pin_o(sync_pin_i));

  initial clk_i = 1'h0;
  always #50 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic ext_acc(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    ext_wr_i = wr;
    ext_rd_i = !wr;
    ext_addr_i = a;
    ext_wdata_i = d;
    @(negedge clk_i);
    ext_wr_i = 1'h0;
    ext_rd_i = 1'h0;
    rd = {24'h0, ext_rdata_o};
    chk("ext_ack", 32'h1, {31'h0, write_acknowledge_o});
  endtask
  task automatic chan_acc(input logic wr, input logic [1:0] c, input logic [7:0] a,
                          input logic [31:0] d);
    @(negedge clk_i);
    chan_wr_i = wr;
    chan_rd_i = !wr;
    chan_sel_i = c;
    chan_addr_i = a;
    chan_wdata_i = d;
    @(negedge clk_i);
    chan_wr_i = 1'h0;
    chan_rd_i = 1'h0;
    rd = chan_rdata_o;
    chk("chan_ack", 32'h1, {31'h0, write_acknowledge_o});
  endtask
  function automatic logic [31:0] watch(input int m);
    if (m == 0) return {28'h0, sleep_o};
    return tuning_oscillator_freq_o[32*(m-1) +: 32];
  endfunction
  task automatic measure(input int m, input int exp, input string what);
    logic [31:0] v0;
    int          n;
    v0 = watch(m);
    n = 0;
    while (watch(m) === v0 && n < 500) begin
      @(negedge clk_i);
      n++;
    end
    chk(what, exp, n);
  endtask
  task automatic pin_pulse(input logic [1:0] p);
    @(negedge clk_i);
    go = 1'h1;
    go_pin = p;
    @(negedge clk_i);
    go = 1'h0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(100 * 3000);
    num_errors++;
    final_report;
  end

  initial begin
    {rst_n_i, ext_wr_i, ext_rd_i, chan_wr_i, chan_rd_i, go} = 6'h00;
    {ext_addr_i, ext_wdata_i, chan_sel_i, chan_addr_i, go_pin} = 23'h0;
    chan_wdata_i = 32'h0;
    num_errors = 0;
    num_checks = 0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'h1;
    chk("sleep_rst", 32'hF, watch(0));
    ext_acc(1'h0, 3'h7, 8'h00);
    chk("unmapped", 32'h0, rd);
    chan_acc(1'h1, 2'h0, 8'h83, 32'h1);
    chan_acc(1'h0, 2'h0, 8'h83, 32'h0);
    chk("start_ho", 32'h1, rd);
    ext_acc(1'h1, 3'h3, 8'h00);
    chk("sleep_clr", 32'h0, watch(0));
    ext_acc(1'h1, 3'h3, 8'h0F);
    chk("sleep_set", 32'hF, watch(0));
    chan_acc(1'h1, 2'h1, 8'h83, 32'h2);
    chan_acc(1'h1, 2'h2, 8'h83, 32'h2);
    ext_acc(1'h1, 3'h5, 8'h16);
    measure(0, 2 + 6, "soft_start");
    chk("soft_mask", 32'h9, watch(0));
    ext_acc(1'h1, 3'h3, 8'h0F);
    chan_acc(1'h1, 2'h0, 8'h86, 32'h2);
    chan_acc(1'h1, 2'h3, 8'h86, 32'h2);
    chan_acc(1'h1, 2'h1, 8'h86, 32'h3);
    chan_acc(1'h1, 2'h0, 8'h83, 32'h3);
    chan_acc(1'h1, 2'h3, 8'h83, 32'h3);
    ext_acc(1'h1, 3'h4, 8'h14);
    pin_pulse(2'h2);
    measure(0, 3 + 3, "pin_start");
    chk("pin_mask", 32'h6, watch(0));
    ext_acc(1'h1, 3'h4, 8'h00);
    chan_acc(1'h1, 2'h0, 8'h85, 32'h1234_5678);
    chk("freq_now", 32'h1234_5678, watch(1));
    chan_acc(1'h1, 2'h1, 8'h84, 32'h4);
    chan_acc(1'h1, 2'h1, 8'h85, 32'hA5A5_0001);
    chk("freq_pend", 32'h0, watch(2));
    ext_acc(1'h1, 3'h5, 8'h22);
    measure(2, 4 + 7, "soft_hop");
    chk("freq_hop", 32'hA5A5_0001, watch(2));
    ext_acc(1'h0, 3'h5, 8'h00);
    chk("soft_ctrl", 32'h22, rd);
    chan_acc(1'h1, 2'h2, 8'h86, 32'h3);
    chan_acc(1'h1, 2'h2, 8'h84, 32'h2);
    chan_acc(1'h1, 2'h2, 8'h85, 32'h0F0F_0F0F);
    ext_acc(1'h1, 3'h4, 8'h28);
    pin_pulse(2'h3);
    measure(3, 2 + 5, "pin_hop");
    chk("freq_pin", 32'h0F0F_0F0F, watch(3));
    chk("freq_ch0", 32'h1234_5678, watch(1));
    chk("freq_ch3", 32'h0, watch(4));
    repeat (30) @(negedge clk_i);
    chk("idle", 32'h0, {24'h0, hop_busy_o, start_busy_o});
    final_report;
  end
endmodule
